// ==== asrp_pkg.sv ====
/*
 * constants, state types and timing counts shared by both ends of the
 * serial result port of a delta-sigma converter.
 * assumes one 50 MHz clock that both ends and the link run on.
 */
// Behaviour
// (RQ1) cs fall with sck low picks external clock
// (RQ2) data pin released while cs high
// (RQ3) cs low: data pin shows busy flag
// (RQ4) finished conversion enters sleep by itself
// (RQ5) sleep holds result until sck rise, cs low
// (RQ6) data changes on sck fall, sampled rising
// (RQ7) external: 32nd fall starts conversion, pin high
// (RQ8) external: cs rise in output aborts, reconverts
// (RQ9) host may hold cs low or raise it
// (RQ10) mode latched at power-on end, sck low
// (RQ11) two-wire: result loaded at flag fall
// (RQ12) floating or high sck picks internal clock
// (RQ13) internal: cs fall drives sck low, flag
// (RQ14) internal: output starts after status delay
// (RQ15) host raises cs early to stay asleep
// (RQ16) internal: 32 rises, sck stays high, reconvert
// (RQ17) internal: cs rise in output aborts, reconverts
// (RQ18) pull-up off whenever sck pin low
// (RQ19) cs rise in sleep check restores pull-up
// (RQ20) internal sck is conversion clock over eight
// (RQ21) result shifted out most significant first
package asrp_pkg;
   // ==========================================================
   // clock and word
   localparam int CLK_PERIOD_NS = 20;
   localparam int WORD_W = 32;             // flag plus result bits
   localparam int RES_W = WORD_W - 1;      // bits fed by the user
   localparam int BCNT_W = 6;
   localparam logic [BCNT_W-1:0] LAST_BIT = 6'h1F;
   localparam logic [BCNT_W-1:0] BITS_PER_WORD = 6'h20;

   // ==========================================================
   // timing
   localparam int POR_TIME_NS = 500_000;   // power-on reset length
   localparam int POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_TIME_NS = 147_000_000;
   localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int STATUS_TEST_DELAY_NS = 26_000;
   localparam int TST_DLY_CYC =
      (STATUS_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXT_OSC_DELAY_TENTHS = 36;  // 3.6 oscillator periods
   localparam int EXT_DLY_CYC = (EXT_OSC_DELAY_TENTHS + 9) / 10;
   localparam int INT_SCK_DIV = 8;
   localparam int INT_HALF = INT_SCK_DIV / 2;
   localparam int HOST_HALF = 2;            // host sck half period
   localparam int FIFO_DEPTH = 16;

   // ==========================================================
   // state types
   typedef enum logic [1:0] {
      ASRP_CONV  = 2'h0,
      ASRP_SLEEP = 2'h1,
      ASRP_OUT   = 2'h3
   } asrp_dev_st_e;

   typedef enum logic [1:0] {
      ASRP_IDLE = 2'h0,
      ASRP_SEL  = 2'h1,
      ASRP_XFER = 2'h3,
      ASRP_DONE = 2'h2
   } asrp_host_st_e;
endpackage

// ==== asrp_link_if.sv ====
/*
 * the three-wire link between converter end and host end.
 * assumes a released data pin reads high and a released sck pin
 * reads high only while the converter's weak pull-up is on.
 */
interface asrp_link_if;
   // ==========================================================
   // pin drives
   logic cs_n;
   logic sck_dev;
   logic sck_dev_oe;
   logic sck_pu;
   logic sck_host;
   logic sck_host_oe;
   logic sdo;
   logic sdo_oe;
   logic sck_pin;
   logic sdo_pin;

   // resolved wire levels
   assign sck_pin = sck_dev_oe ? sck_dev : (sck_host_oe ? sck_host : sck_pu);
   assign sdo_pin = sdo_oe ? sdo : 1'b1;

   modport dev (input cs_n, sck_pin,
                output sck_dev, sck_dev_oe, sck_pu, sdo, sdo_oe);
   modport host (input sck_pin, sdo_pin,
                 output cs_n, sck_host, sck_host_oe);
endinterface

// ==== asrp_fifo.sv ====
/*
 * result fifo with valid/ready on both sides.
 * assumes one clock; depth a power of two.
 */
module asrp_fifo
   import asrp_pkg::*;
#(
   parameter int W = RES_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic [AW:0] nxt_cnt;
   logic push;
   logic pop;

   // ==========================================================
   // handshakes
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data_o = mem[rd_ff];

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ff] <= in_data_i;
      end
   end

   // pointers and registered flags
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wr_ff <= wr_ff + AW'(push);
         rd_ff <= rd_ff + AW'(pop);
         cnt_ff <= nxt_cnt;
         in_ready_o <= (nxt_cnt != (AW+1)'(DEPTH));
         out_valid_o <= (nxt_cnt != '0);
      end
   end
endmodule // asrp_fifo

// ==== asrp_dev_end.sv ====
/*
 * converter end: conversion timing, sleep, clock-mode selection,
 * 32-bit result shift in external and internal serial clock modes.
 * assumes link inputs synchronous to clk_i; results come from the
 * user through a fifo, one word per conversion.
 */
module asrp_dev_end
   import asrp_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYC,
   parameter int CONV_CYCLES = CONV_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // link
   asrp_link_if.dev link,
   // result feed
   input wire logic smp_valid_i,
   input wire logic [RES_W-1:0] smp_data_i,
   output logic smp_ready_o,
   // status
   input wire logic conv_clock_source_pin_i,
   output logic busy_o,
   output logic ext_mode_o
);
   if (POR_CYCLES < 1 || CONV_CYCLES < 1) begin : g_bad_cnt
      $error("counts must be at least one");
   end

   asrp_dev_st_e st_ff, nxt_st;
   logic [WORD_W-1:0] sh_ff, nxt_sh;
   logic [BCNT_W-1:0] bcnt_ff, nxt_bcnt;
   logic [2:0] div_ff, nxt_div;
   logic sck_ff, nxt_sck;
   logic [31:0] por_ff;
   logic por_done_ff;
   logic [31:0] conv_ff;
   logic [15:0] tst_ff;
   logic ext_ff, nxt_ext;
   logic cs_q_ff;
   logic sck_q_ff;
   logic cs_fall, cs_rise, sck_rise, sck_fall;
   logic conv_end;
   logic fifo_valid;
   logic [RES_W-1:0] fifo_data;
   logic tst_hit;
   logic sdo_ff, sdo_oe_ff, sck_oe_ff, pu_ff;

   // ==========================================================
   // result fifo, drained once per finished conversion
   asrp_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(smp_valid_i),
      .in_data_i(smp_data_i),
      .in_ready_o(smp_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(conv_end)
   );

   // ==========================================================
   // edge detection on the link pins
   assign cs_fall = cs_q_ff & ~link.cs_n;
   assign cs_rise = ~cs_q_ff & link.cs_n;
   assign sck_rise = ~sck_q_ff & link.sck_pin;
   assign sck_fall = sck_q_ff & ~link.sck_pin;
   assign conv_end = (st_ff == ASRP_CONV) & fifo_valid
                     & (conv_ff >= 32'(CONV_CYCLES - 1));
   assign tst_hit = conv_clock_source_pin_i ? (tst_ff >= 16'(EXT_DLY_CYC))
                                            : (tst_ff >= 16'(TST_DLY_CYC));

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cs_q_ff <= 1'b1;
         sck_q_ff <= 1'b1; // idle pin level is the pull-up's
      end else begin
         cs_q_ff <= link.cs_n;
         sck_q_ff <= link.sck_pin;
      end
   end

   // ==========================================================
   // clock mode: caught at power-on end and at every cs fall
   always_comb begin
      nxt_ext = ext_ff;
      if (!por_done_ff && por_ff >= 32'(POR_CYCLES - 1)) begin
         nxt_ext = ~link.sck_pin; // see (RQ10)
      end else if (cs_fall) begin
         nxt_ext = ~link.sck_pin; // see (RQ1) see (RQ12)
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         por_ff <= '0;
         por_done_ff <= 1'b0;
         ext_ff <= 1'b0;
      end else begin
         if (!por_done_ff) begin
            por_ff <= por_ff + 32'h0000_0001;
         end
         if (por_ff >= 32'(POR_CYCLES - 1)) begin
            por_done_ff <= 1'b1;
         end
         ext_ff <= nxt_ext;
      end
   end

   // ==========================================================
   // conversion timer and status test delay
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_ff <= '0;
         tst_ff <= '0;
      end else begin
         if (st_ff != ASRP_CONV) begin
            conv_ff <= '0;
         end else if (conv_ff < 32'(CONV_CYCLES - 1)) begin
            conv_ff <= conv_ff + 32'h0000_0001;
         end
         // runs from cs fall in sleep, or from flag fall with cs low
         if (st_ff == ASRP_SLEEP && !link.cs_n && !ext_ff) begin
            tst_ff <= tst_ff + 16'h0001; // see (RQ14)
         end else begin
            tst_ff <= '0;
         end
      end
   end

   // ==========================================================
   // state, shift register, bit count and internal sck
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bcnt = bcnt_ff;
      nxt_div = div_ff;
      nxt_sck = sck_ff;
      if (cs_fall && !nxt_ext) begin
         nxt_sck = 1'b0; // see (RQ13)
      end
      unique case (st_ff)
         ASRP_CONV: begin
            if (conv_end) begin
               nxt_st = ASRP_SLEEP; // see (RQ4)
               nxt_sh = {1'b0, fifo_data}; // see (RQ11)
            end
         end
         ASRP_SLEEP: begin
            if (ext_ff && !link.cs_n && sck_rise) begin
               nxt_st = ASRP_OUT; // see (RQ5)
               nxt_bcnt = '0;
            end else if (!ext_ff && !link.cs_n && tst_hit) begin
               nxt_st = ASRP_OUT; // see (RQ14)
               nxt_sck = 1'b1;
               nxt_bcnt = 6'h01;
               nxt_div = '0;
            end
         end
         ASRP_OUT: begin
            if (cs_rise) begin
               nxt_st = ASRP_CONV; // see (RQ8) see (RQ17)
            end else if (ext_ff) begin
               if (sck_fall) begin
                  nxt_sh = {sh_ff[WORD_W-2:0], 1'b0}; // see (RQ6) (RQ21)
                  nxt_bcnt = bcnt_ff + 6'h01;
                  if (bcnt_ff == LAST_BIT) begin
                     nxt_st = ASRP_CONV; // see (RQ7)
                  end
               end
            end else if (div_ff == 3'(INT_HALF - 1)) begin
               nxt_div = '0; // see (RQ20)
               nxt_sck = ~sck_ff;
               if (sck_ff) begin
                  nxt_sh = {sh_ff[WORD_W-2:0], 1'b0}; // see (RQ6)
               end else begin
                  nxt_bcnt = bcnt_ff + 6'h01;
                  if (bcnt_ff + 6'h01 == BITS_PER_WORD) begin
                     nxt_st = ASRP_CONV; // see (RQ16)
                  end
               end
            end else begin
               nxt_div = div_ff + 3'h1;
            end
         end
         default: nxt_st = ASRP_CONV;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff <= ASRP_CONV;
         sh_ff <= '0;
         bcnt_ff <= '0;
         div_ff <= '0;
         sck_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         bcnt_ff <= nxt_bcnt;
         div_ff <= nxt_div;
         sck_ff <= nxt_sck;
      end
   end

   // ==========================================================
   // pin drivers, all registered
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sdo_ff <= 1'b1;
         sdo_oe_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         busy_o <= 1'b1;
         ext_mode_o <= 1'b0;
      end else begin
         // flag high while converting, else the current bit; the flag
         // follows the state so the last bit stands through its rise
         sdo_ff <= (st_ff == ASRP_CONV) ? 1'b1 : nxt_sh[WORD_W-1]; // see (RQ3)
         sdo_oe_ff <= ~link.cs_n; // see (RQ2) see (RQ3)
         sck_oe_ff <= ~nxt_ext & ~link.cs_n; // see (RQ13)
         busy_o <= (nxt_st == ASRP_CONV);
         ext_mode_o <= nxt_ext;
      end
   end

   // weak pull-up on sck
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pu_ff <= 1'b1;
      end else if (cs_rise && !ext_ff) begin
         pu_ff <= 1'b1; // see (RQ19)
      end else if (!link.sck_pin) begin
         pu_ff <= 1'b0; // see (RQ18)
      end else begin
         pu_ff <= 1'b1;
      end
   end

   assign link.sdo = sdo_ff;
   assign link.sdo_oe = sdo_oe_ff;
   assign link.sck_dev = sck_ff;
   assign link.sck_dev_oe = sck_oe_ff;
   assign link.sck_pu = pu_ff;
endmodule // asrp_dev_end

// ==== asrp_host_end.sv ====
/*
 * host end: lowers cs, waits for the done flag, clocks or follows
 * 32 sck rises and returns the word; may abort early.
 * assumes link inputs synchronous to clk_i.
 */
module asrp_host_end
   import asrp_pkg::*;
#(
   parameter int HALF = HOST_HALF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // link
   asrp_link_if.host link,
   // command
   input wire logic rd_req_i,
   input wire logic ext_sel_i,
   input wire logic abort_i,
   output logic busy_o,
   // result
   output logic rd_valid_o,
   output logic [WORD_W-1:0] rd_data_o
);
   if (HALF < 1 || HALF > 15) begin : g_bad_half
      $error("half period out of range");
   end

   asrp_host_st_e st_ff;
   logic ext_ff;
   logic cs_n_ff;
   logic sck_ff;
   logic sck_oe_ff;
   logic sck_q_ff;
   logic [3:0] div_ff;
   logic [BCNT_W-1:0] bcnt_ff;
   logic [WORD_W-1:0] sh_ff;
   logic pin_rise;

   assign pin_rise = ~sck_q_ff & link.sck_pin;

   // ==========================================================
   // transfer sequencer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff <= ASRP_IDLE;
         ext_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         sck_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         sck_q_ff <= 1'b1;
         div_ff <= '0;
         bcnt_ff <= '0;
         sh_ff <= '0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
         busy_o <= 1'b0;
      end else begin
         sck_q_ff <= link.sck_pin;
         rd_valid_o <= 1'b0;
         unique case (st_ff)
            ASRP_IDLE: begin
               // low sck before cs fall selects external mode
               sck_ff <= 1'b0;
               sck_oe_ff <= ext_sel_i; // see (RQ1) see (RQ10)
               ext_ff <= ext_sel_i;
               busy_o <= 1'b0;
               if (rd_req_i) begin
                  st_ff <= ASRP_SEL;
                  busy_o <= 1'b1;
               end
            end
            ASRP_SEL: begin
               cs_n_ff <= 1'b0;
               bcnt_ff <= '0;
               div_ff <= '0;
               if (abort_i) begin
                  cs_n_ff <= 1'b1; // see (RQ15)
                  st_ff <= ASRP_IDLE;
               end else if (!cs_n_ff && !link.sdo_pin) begin
                  st_ff <= ASRP_XFER; // flag low: result ready
               end
            end
            ASRP_XFER: begin
               if (abort_i) begin
                  cs_n_ff <= 1'b1; // see (RQ8) see (RQ17)
                  st_ff <= ASRP_IDLE;
               end else if (ext_ff) begin
                  if (div_ff == 4'(HALF - 1)) begin
                     div_ff <= '0;
                     sck_ff <= ~sck_ff;
                     if (!sck_ff) begin
                        sh_ff <= {sh_ff[WORD_W-2:0], link.sdo_pin}; // (RQ6)
                     end else begin
                        bcnt_ff <= bcnt_ff + 6'h01;
                        if (bcnt_ff == LAST_BIT) begin
                           st_ff <= ASRP_DONE;
                        end
                     end
                  end else begin
                     div_ff <= div_ff + 4'h1;
                  end
               end else if (pin_rise) begin
                  sh_ff <= {sh_ff[WORD_W-2:0], link.sdo_pin}; // see (RQ6)
                  bcnt_ff <= bcnt_ff + 6'h01;
                  if (bcnt_ff == LAST_BIT) begin
                     st_ff <= ASRP_DONE;
                  end
               end
            end
            ASRP_DONE: begin
               cs_n_ff <= 1'b1; // see (RQ9)
               rd_valid_o <= 1'b1;
               rd_data_o <= sh_ff;
               st_ff <= ASRP_IDLE;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sck_host = sck_ff;
   assign link.sck_host_oe = sck_oe_ff;
endmodule // asrp_host_end

// ==== asrp_link_sva.sv ====
/*
 * assertions on the three-wire link between converter and host end.
 * assumes all link signals settle on clk_i; resetn_i async active low.
 */
module asrp_link_sva (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // link
   input wire logic cs_n,
   input wire logic sck_dev,
   input wire logic sck_dev_oe,
   input wire logic sck_pu,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic sck_pin
);
   // ==========================================================
   // helper logic
   logic sck_q_ff;
   logic [5:0] rise_cnt_ff;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // count sck rises while selected
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sck_q_ff <= 1'b1;
         rise_cnt_ff <= 6'h00;
      end else begin
         sck_q_ff <= sck_pin;
         if (cs_n) begin
            rise_cnt_ff <= 6'h00;
         end else if (sck_pin && !sck_q_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 6'h01;
         end
      end
   end

   // ==========================================================
   // link checks
   a_sdo_released: assert property (
      cs_n && $past(cs_n) |-> !sdo_oe)
      else $error("data pin driven while deselected");
   a_flag_driven: assert property ($fell(cs_n) |=> sdo_oe)
      else $error("data pin not driven after select");
   a_ext_no_drive: assert property (
      $fell(cs_n) && !sck_pin |=> !sck_dev_oe [*4])
      else $error("converter drives sck in external mode");
   a_int_sck_low: assert property (
      $fell(cs_n) && sck_pin |=> sck_dev_oe && !sck_dev)
      else $error("internal mode sck not pulled low");
   a_pullup_off: assert property (
      !sck_pin && $past(!sck_pin) |-> !sck_pu)
      else $error("pull-up on while sck low");
   a_pullup_back: assert property (
      $rose(cs_n) && sck_dev_oe |=> sck_pu)
      else $error("pull-up not restored");
   a_sck_half: assert property (
      $fell(sck_dev) && sck_dev_oe && $past(sck_dev_oe)
      |-> $past(sck_dev, 4) && !$past(sck_dev, 5))
      else $error("internal sck high phase not four cycles");
   a_hold_high: assert property (
      sck_pin && $past(sck_pin) && sdo_oe && $past(sdo_oe) |-> !$fell(sdo))
      else $error("data fell while sck high");
   a_word_len: assert property (rise_cnt_ff <= 6'h20)
      else $error("more than 32 sck rises");
   a_int_end: assert property (
      $rose(sck_pin) && rise_cnt_ff == 6'h1F && sck_dev_oe
      |-> ##[1:2] (sdo && sck_pin))
      else $error("no busy flag after last internal rise");
   a_ext_end: assert property (
      $fell(sck_pin) && rise_cnt_ff == 6'h20 |-> ##[1:2] (sdo || !sdo_oe))
      else $error("no busy flag after last external fall");
endmodule // asrp_link_sva

// ==== adc_serial_result_port_tb_top.sv ====
/*
 * bench joining converter end and host end over the link.
 * assumes short power-on and conversion counts set below.
 */
module adc_serial_result_port_tb_top import asrp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // signals
   localparam int POR_N = 20;
   localparam int CONV_N = 50;
   typedef struct {logic ext; logic osc; logic ab; logic [30:0] d;
      logic [31:0] exp;} asrp_row_s;
   logic clk_i, resetn_i, smp_valid_i, osc_i, rd_req_i, ext_sel_i, abort_i;
   logic smp_ready_o, dev_busy, host_busy, ext_mode_o, rd_valid_o, sck_q;
   logic [30:0] smp_data_i;
   logic [31:0] rd_data_o, mon_w;
   logic [30:0] q[$];
   int fails, n_compared, mon_n, lat, i, r, n, dly;
   asrp_row_s rows[6];

   asrp_link_if link ();
   asrp_dev_end #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N)) asrp_dev_end_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .link(link),
      .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
      .smp_ready_o(smp_ready_o), .conv_clock_source_pin_i(osc_i),
      .busy_o(dev_busy), .ext_mode_o(ext_mode_o));
   asrp_host_end asrp_host_end_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .link(link), .rd_req_i(rd_req_i), .ext_sel_i(ext_sel_i),
      .abort_i(abort_i), .busy_o(host_busy), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o));
   asrp_link_sva asrp_link_sva_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .cs_n(link.cs_n), .sck_dev(link.sck_dev),
      .sck_dev_oe(link.sck_dev_oe), .sck_pu(link.sck_pu), .sdo(link.sdo),
      .sdo_oe(link.sdo_oe), .sck_pin(link.sck_pin));

   // clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // wire monitor: bits taken at sck rises, cycles to first rise
   always @(negedge clk_i) begin
      sck_q <= link.sck_pin;
      if (link.cs_n !== 1'b0) begin
         mon_n <= 0;
         lat <= 0;
      end else begin
         if (mon_n == 0) lat <= lat + 1;
         if (link.sck_pin === 1'b1 && sck_q === 1'b0) begin
            mon_w <= {mon_w[30:0], link.sdo_pin};
            mon_n <= mon_n + 1;
         end
      end
   end

   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic push(input logic [30:0] d);
      @(negedge clk_i);
      smp_data_i = d;
      smp_valid_i = 1'b1;
      for (i = 0; i < 50 && smp_ready_o !== 1'b1; i++) @(negedge clk_i);
      @(negedge clk_i);
      smp_valid_i = 1'b0;
   endtask

   task automatic wait_idle();
      for (i = 0; i < 200 && dev_busy !== 1'b0; i++) @(negedge clk_i);
      chk(32'(dev_busy), 32'h0000_0000);
   endtask

   task automatic start(input logic ext, input logic osc);
      @(negedge clk_i);
      ext_sel_i = ext;
      osc_i = osc;
      rd_req_i = 1'b1;
      @(negedge clk_i);
      rd_req_i = 1'b0;
   endtask

   task automatic wait_valid();
      for (i = 0; i < 4000 && rd_valid_o !== 1'b1; i++) @(negedge clk_i);
      chk(32'(rd_valid_o), 32'h0000_0001);
   endtask

   task automatic do_reset(input logic ext);
      @(negedge clk_i);
      ext_sel_i = ext;
      resetn_i = 1'b0;
      repeat (12) @(negedge clk_i);
      chk(32'({link.cs_n, link.sdo_oe, link.sck_pu, link.sck_dev_oe,
         link.sck_host_oe, dev_busy, host_busy, rd_valid_o, smp_ready_o}),
         32'h0000_0148);
      resetn_i = 1'b1;
      repeat (POR_N + 5) @(negedge clk_i);
      chk(32'(ext_mode_o), 32'(ext));
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge clk_i);
      fails++;
      tally_and_finish();
   end

   // ==========================================================
   // main sequence
   initial begin
      {smp_valid_i, osc_i, rd_req_i, abort_i, fails, n_compared} = '0;
      resetn_i = 1'b0;
      ext_sel_i = 1'b0;
      smp_data_i = 31'h0000_0000;
      rows = '{'{0, 0, 0, 31'h0000_0001, 32'h0000_0001},
         '{0, 1, 1, 31'h0000_1234, 32'h0000_0001},
         '{0, 1, 0, 31'h5555_5555, 32'h5555_5555},
         '{1, 1, 1, 31'h0000_4321, 32'h0000_0001},
         '{1, 1, 0, 31'h7FFF_FFFF, 32'h7FFF_FFFF},
         '{1, 1, 0, 31'h2AAA_AAAA, 32'h2AAA_AAAA}};
      do_reset(1'b0);
      for (r = 0; r < 6; r++) begin
         push(rows[r].d);
         wait_idle();
         start(rows[r].ext, rows[r].osc);
         if (rows[r].ab) begin
            for (i = 0; i < 4000 && mon_n < 3; i++) @(negedge clk_i);
            abort_i = 1'b1;
            for (i = 0; i < 200 && host_busy !== 1'b0; i++) @(negedge clk_i);
            abort_i = 1'b0;
            chk(32'(dev_busy), rows[r].exp);
         end else begin
            wait_valid();
            dly = rows[r].osc ? EXT_DLY_CYC : TST_DLY_CYC;
            chk(rd_data_o, rows[r].exp);
            chk(mon_w, rows[r].exp);
            chk(32'(ext_mode_o), 32'(rows[r].ext));
            if (!rows[r].ext) begin
               chk(32'(lat >= dly && lat <= dly + 6), 32'h0000_0001);
            end
         end
      end
      // fill the buffer while a word is held asleep, then drain
      push(31'h0ABC_DEF0);
      q.push_back(31'h0ABC_DEF0);
      wait_idle();
      n = 0;
      @(negedge clk_i);
      smp_valid_i = 1'b1;
      for (r = 0; r < 24; r++) begin
         if (smp_ready_o === 1'b1) begin
            n++;
            smp_data_i = 31'(r * 31'h0101_0101);
            q.push_back(smp_data_i);
         end
         @(negedge clk_i);
      end
      smp_valid_i = 1'b0;
      chk(32'(n), 32'h0000_0010);
      for (r = 0; r < 17; r++) begin
         start(1'b1, 1'b1);
         wait_valid();
         chk(rd_data_o, {1'b0, q.pop_front()});
      end
      // status check asleep: cs raised before the first internal rise
      do_reset(1'b0);
      push(31'h1357_9BDF);
      wait_idle();
      start(1'b0, 1'b0);
      repeat (20) @(negedge clk_i);
      abort_i = 1'b1;
      for (i = 0; i < 200 && host_busy !== 1'b0; i++) @(negedge clk_i);
      abort_i = 1'b0;
      chk(32'(dev_busy), 32'h0000_0000);
      start(1'b0, 1'b1);
      wait_valid();
      chk(rd_data_o, 32'h1357_9BDF);
      do_reset(1'b1);
      tally_and_finish();
   end
endmodule // adc_serial_result_port_tb_top
